// ---- logic/ccr_pkg.sv ----
/*
  Shared types and constants for the coherence collision resolver.
  Assumes a single agent clock domain and the outstanding table fed by the local agent.
*/
package ccr_pkg;

  // Fixed sizes of the agent
  localparam int CCR_GRAN_W = 29;
  localparam int CCR_SRC_W = 8;
  localparam int CCR_OUT_N = 4;
  localparam int CCR_IDX_W = 2;

  // Values after reset
  localparam logic [CCR_OUT_N-1:0] CCR_VALID_RST = 4'h0;
  localparam logic [CCR_GRAN_W-1:0] CCR_ADDR_RST = 29'h0000000;
  localparam logic [CCR_SRC_W-1:0] CCR_SRC_RST = 8'h00;

  // Coherence transaction types
  typedef enum logic [4:0] {
    CCR_READ_HOME,
    CCR_IREAD_HOME,
    CCR_READ_OWNER,
    CCR_READ_TO_OWN_HOME,
    CCR_READ_TO_OWN_OWNER,
    CCR_DKILL_HOME,
    CCR_DKILL_SHARER,
    CCR_CASTOUT,
    CCR_TLBIE,
    CCR_TLBSYNC,
    CCR_IKILL_HOME,
    CCR_IKILL_SHARER,
    CCR_FLUSH,
    CCR_IO_READ_HOME,
    CCR_IO_READ_OWNER
  } ccr_ttype_t;

  // Resolution handed back for an incoming request
  typedef enum logic [1:0] {
    CCR_RES_DONE,
    CCR_RES_RETRY,
    CCR_RES_ERROR,
    CCR_RES_PASS
  } ccr_res_t;

  // Internal action chosen by the collision lookup
  typedef enum logic [2:0] {
    CCR_ACT_PASS,
    CCR_ACT_ERROR,
    CCR_ACT_RETRY,
    CCR_ACT_FWD_DONE,
    CCR_ACT_DIR_DONE,
    CCR_ACT_FWD_KILL
  } ccr_act_t;

  // Incoming request from a remote processing element
  typedef struct packed {
    ccr_ttype_t typ;
    logic [CCR_GRAN_W-1:0] addr;
    logic [CCR_SRC_W-1:0] src;
  } ccr_req_t;

  // Answer toward the requestor
  typedef struct packed {
    ccr_res_t code;
    logic [CCR_SRC_W-1:0] dst;
  } ccr_rsp_t;

endpackage

// ---- logic/ccr_resolver.sv ----
/*
  Address-collision resolver: checks each incoming coherence request against the
  locally outstanding requests and answers, forwards or multicasts accordingly.
  Assumes the local agent loads and frees table entries, and that the processor
  and multicast paths acknowledge with one-cycle strobes; directory updates are not acknowledged.
*/
`timescale 1ns/1ps

// Functional notes
// - IREAD_HOME outstanding: home-type hits answer ERROR
// - IREAD_HOME outstanding: owner/sharer hits forward, DONE
// - TLBIE/TLBSYNC hitting IREAD_HOME or READ_OWNER: forward to processor, then DONE
// - READ_OWNER outstanding: home-type hits answer RETRY
// - READ_OWNER outstanding: owner/sharer hits answer ERROR
// - READ_OWNER outstanding: CASTOUT updates directory, DONE
// - READ_OWNER outstanding: IKILL_HOME forwards, multicasts IKILL_SHARER
module ccr_resolver
  import ccr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic alloc_i,
  input wire logic [CCR_IDX_W-1:0] alloc_idx_i,
  input wire ccr_ttype_t alloc_typ_i,
  input wire logic [CCR_GRAN_W-1:0] alloc_addr_i,
  input wire logic free_i,
  input wire logic [CCR_IDX_W-1:0] free_idx_i,
  input wire logic in_valid_i,
  input wire ccr_req_t in_req_i,
  output logic in_ready_o,
  output logic rsp_valid_o,
  output ccr_rsp_t rsp_o,
  input wire logic rsp_ready_i,
  output logic fwd_valid_o,
  output ccr_req_t fwd_o,
  input wire logic fwd_ack_i,
  output logic dir_upd_o,
  output logic [CCR_GRAN_W-1:0] dir_addr_o,
  output logic kill_valid_o,
  output logic [CCR_SRC_W-1:0] kill_excl_o,
  input wire logic kill_ack_i
);

  typedef enum logic [1:0] {S_IDLE, S_FWD, S_KILL, S_RSP} ccr_state_t;

  ccr_state_t state_reg;
  logic [CCR_OUT_N-1:0] valid_reg;
  ccr_ttype_t otyp_reg [CCR_OUT_N];
  logic [CCR_GRAN_W-1:0] oaddr_reg [CCR_OUT_N];
  ccr_req_t cap_reg;
  ccr_act_t act_reg;
  ccr_res_t code_reg;
  logic dir_upd_reg;
  logic [CCR_OUT_N-1:0] hit;
  ccr_ttype_t hit_typ;
  logic any_hit;
  ccr_act_t act_next;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Resolution for one outstanding/incoming pair; other outstanding types
  // are left to their own resolvers, so they pass through untouched.
  function automatic ccr_act_t resolve(input ccr_ttype_t otyp, input ccr_ttype_t ityp);
    ccr_act_t a;
    a = CCR_ACT_PASS;
    if (ityp == CCR_TLBIE || ityp == CCR_TLBSYNC) begin
      if (otyp == CCR_IREAD_HOME || otyp == CCR_READ_OWNER) begin
        a = CCR_ACT_FWD_DONE;
      end
    end else if (otyp == CCR_IREAD_HOME) begin
      case (ityp)
        CCR_READ_OWNER, CCR_READ_TO_OWN_OWNER, CCR_DKILL_SHARER,
        CCR_IKILL_SHARER, CCR_IO_READ_OWNER: a = CCR_ACT_FWD_DONE;
        default: a = CCR_ACT_ERROR;
      endcase
    end else if (otyp == CCR_READ_OWNER) begin
      case (ityp)
        CCR_CASTOUT: a = CCR_ACT_DIR_DONE;
        CCR_IKILL_HOME: a = CCR_ACT_FWD_KILL;
        CCR_READ_OWNER, CCR_READ_TO_OWN_OWNER, CCR_DKILL_SHARER,
        CCR_IKILL_SHARER, CCR_IO_READ_OWNER: a = CCR_ACT_ERROR;
        default: a = CCR_ACT_RETRY;
      endcase
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Outstanding table, one compare per entry
  genvar g;
  generate
    for (g = 0; g < CCR_OUT_N; g++) begin : g_ent
      // Allocation wins over a free of the same entry in one cycle
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          valid_reg[g] <= CCR_VALID_RST[g];
          otyp_reg[g] <= CCR_READ_HOME;
          oaddr_reg[g] <= CCR_ADDR_RST;
        end else if (alloc_i && alloc_idx_i == CCR_IDX_W'(g)) begin
          valid_reg[g] <= 1'b1;
          otyp_reg[g] <= alloc_typ_i;
          oaddr_reg[g] <= alloc_addr_i;
        end else if (free_i && free_idx_i == CCR_IDX_W'(g)) begin
          valid_reg[g] <= 1'b0;
        end
      end
      assign hit[g] = valid_reg[g] && oaddr_reg[g] == in_req_i.addr;
    end
  endgenerate

  // Lowest hit entry selects the resolution
  always_comb begin
    hit_typ = CCR_READ_HOME;
    any_hit = 1'b0;
    for (int i = CCR_OUT_N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_typ = otyp_reg[i];
        any_hit = 1'b1;
      end
    end
    act_next = any_hit ? resolve(hit_typ, in_req_i.typ) : CCR_ACT_PASS;
  end

  assign in_ready_o = state_reg == S_IDLE;
  assign take = in_valid_i && in_ready_o;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: forward first, then multicast without an answer (CCR_ACT_FWD_KILL) or answer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            case (act_next)
              CCR_ACT_FWD_DONE, CCR_ACT_FWD_KILL: state_reg <= S_FWD;
              default: state_reg <= S_RSP;
            endcase
          end
        end
        S_FWD: begin
          if (fwd_ack_i) begin
            state_reg <= (act_reg == CCR_ACT_FWD_KILL) ? S_KILL : S_RSP;
          end
        end
        S_KILL: begin
          if (kill_ack_i) begin
            state_reg <= S_IDLE;
          end
        end
        S_RSP: begin
          if (rsp_ready_i) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Captured request and chosen action
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_reg <= '{typ: CCR_READ_HOME, addr: CCR_ADDR_RST, src: CCR_SRC_RST};
      act_reg <= CCR_ACT_PASS;
    end else if (take) begin
      cap_reg <= in_req_i;
      act_reg <= act_next;
    end
  end

  // Answer code, fixed at acceptance
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_reg <= CCR_RES_PASS;
    end else if (take) begin
      case (act_next)
        CCR_ACT_ERROR: code_reg <= CCR_RES_ERROR;
        CCR_ACT_RETRY: code_reg <= CCR_RES_RETRY;
        CCR_ACT_PASS: code_reg <= CCR_RES_PASS;
        default: code_reg <= CCR_RES_DONE;
      endcase
    end
  end

  // Directory update pulse; castout needs no processor round trip
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_upd_reg <= 1'b0;
    end else begin
      dir_upd_reg <= take && act_next == CCR_ACT_DIR_DONE;
    end
  end

  assign dir_upd_o = dir_upd_reg;
  assign dir_addr_o = cap_reg.addr;
  assign fwd_valid_o = state_reg == S_FWD;
  assign fwd_o = cap_reg;
  assign kill_valid_o = state_reg == S_KILL;
  assign kill_excl_o = cap_reg.src; // Requestor is left out of the multicast
  assign rsp_valid_o = state_reg == S_RSP;
  assign rsp_o = '{code: code_reg, dst: cap_reg.src};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  iread_err_a: assert property (
    take && any_hit && hit_typ == CCR_IREAD_HOME && in_req_i.typ == CCR_CASTOUT
    |=> rsp_valid_o && rsp_o.code == CCR_RES_ERROR)
    else $error("castout against iread not answered error");

  iread_fwd_a: assert property (
    take && any_hit && hit_typ == CCR_IREAD_HOME && in_req_i.typ == CCR_DKILL_SHARER
    |=> fwd_valid_o && !rsp_valid_o)
    else $error("sharer kill against iread not forwarded");

  tlb_fwd_a: assert property (
    fwd_valid_o && fwd_ack_i && act_reg == CCR_ACT_FWD_DONE
    |=> rsp_valid_o && rsp_o.code == CCR_RES_DONE)
    else $error("forwarded request not followed by done");

  owner_retry_a: assert property (
    take && any_hit && hit_typ == CCR_READ_OWNER && in_req_i.typ == CCR_FLUSH
    |=> rsp_valid_o && rsp_o.code == CCR_RES_RETRY && rsp_o.dst == $past(in_req_i.src))
    else $error("flush against owner read not retried");

  owner_err_a: assert property (
    take && any_hit && hit_typ == CCR_READ_OWNER && in_req_i.typ == CCR_IO_READ_OWNER
    |=> rsp_valid_o && rsp_o.code == CCR_RES_ERROR)
    else $error("owner read against owner read not errored");

  castout_dir_a: assert property (
    take && any_hit && hit_typ == CCR_READ_OWNER && in_req_i.typ == CCR_CASTOUT
    |=> dir_upd_o && dir_addr_o == $past(in_req_i.addr) && rsp_valid_o &&
    rsp_o.code == CCR_RES_DONE)
    else $error("castout against owner read not answered done");

  ikill_kill_a: assert property (
    fwd_valid_o && fwd_ack_i && act_reg == CCR_ACT_FWD_KILL
    |=> kill_valid_o && kill_excl_o == fwd_o.src && !rsp_valid_o)
    else $error("ikill home not multicast after forward");

  no_hit_pass_a: assert property (
    take && !any_hit |=> rsp_valid_o && rsp_o.code == CCR_RES_PASS)
    else $error("request without collision not passed on");

  one_out_a: assert property (
    $onehot0({fwd_valid_o, kill_valid_o, rsp_valid_o}))
    else $error("more than one output strobe active");

endmodule

// ---- verif/ccr_far_model.sv ----
/*
  Far side of the resolver: processor, multicast path and requestor.
  Assumes one transfer in flight; wait_i sets how many cycles each answer is held back.
*/
`timescale 1ns/1ps
module ccr_far_model (
  input wire logic mclk_i,
  input wire logic [3:0] wait_i,
  input wire logic fwd_valid_i,
  input wire logic kill_valid_i,
  input wire logic rsp_valid_i,
  output logic fwd_ack_o = 1'b0,
  output logic kill_ack_o = 1'b0,
  output logic rsp_ready_o = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // Acks are one-cycle strobes, so drop them before counting again
  always @(negedge mclk_i) begin
    if (fwd_ack_o || kill_ack_o || rsp_ready_o) begin
      {fwd_ack_o, kill_ack_o, rsp_ready_o} <= 3'h0;
      cnt <= 4'h0;
    end else if (fwd_valid_i || kill_valid_i || rsp_valid_i) begin
      if (cnt == wait_i)
        {fwd_ack_o, kill_ack_o, rsp_ready_o} <= {fwd_valid_i, kill_valid_i, rsp_valid_i};
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ---- verif/coherence_collision_resolver_test.sv ----
/*
  Bench for the collision resolver: loads the outstanding table and sends requests.
  Assumes ccr_far_model answers the processor, multicast and response paths.
*/
`timescale 1ns/1ps
module coherence_collision_resolver_test;
  import ccr_pkg::*;
  logic mclk_i = 1'b0, nrst_i = 1'b0, alloc_i = 1'b0, free_i = 1'b0, in_valid_i = 1'b0;
  logic [CCR_IDX_W-1:0] alloc_idx_i = '0, free_idx_i = '0;
  ccr_ttype_t alloc_typ_i = CCR_READ_HOME;
  logic [CCR_GRAN_W-1:0] alloc_addr_i = '0, dir_addr_o;
  ccr_req_t in_req_i = '0, fwd_o;
  ccr_rsp_t rsp_o;
  logic in_ready_o, rsp_valid_o, rsp_ready_i, fwd_valid_o, fwd_ack_i, dir_upd_o;
  logic kill_valid_o, kill_ack_i;
  logic [CCR_SRC_W-1:0] kill_excl_o;
  logic [3:0] wait_i = 4'h0;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  // Outcome: {answered, code, forwarded, directory, multicast}
  localparam logic [5:0] ERR = {1'b1, CCR_RES_ERROR, 3'h0}, RTY = {1'b1, CCR_RES_RETRY, 3'h0};
  localparam logic [5:0] FWD = {1'b1, CCR_RES_DONE, 3'h4}, DIR = {1'b1, CCR_RES_DONE, 3'h2};
  localparam logic [5:0] PAS = {1'b1, CCR_RES_PASS, 3'h0}, KIL = 6'h05;
  ccr_ttype_t home_l[6] = '{CCR_READ_HOME, CCR_IREAD_HOME, CCR_READ_TO_OWN_HOME,
    CCR_DKILL_HOME, CCR_FLUSH, CCR_IO_READ_HOME};
  ccr_ttype_t own_l[5] = '{CCR_READ_OWNER, CCR_READ_TO_OWN_OWNER, CCR_DKILL_SHARER,
    CCR_IKILL_SHARER, CCR_IO_READ_OWNER};

  ccr_resolver DUT (.mclk_i, .nrst_i, .alloc_i, .alloc_idx_i, .alloc_typ_i, .alloc_addr_i,
    .free_i, .free_idx_i, .in_valid_i, .in_req_i, .in_ready_o, .rsp_valid_o, .rsp_o,
    .rsp_ready_i, .fwd_valid_o, .fwd_o, .fwd_ack_i, .dir_upd_o, .dir_addr_o, .kill_valid_o,
    .kill_excl_o, .kill_ack_i);
  ccr_far_model far (.mclk_i, .wait_i, .fwd_valid_i(fwd_valid_o), .kill_valid_i(kill_valid_o),
    .rsp_valid_i(rsp_valid_o), .fwd_ack_o(fwd_ack_i), .kill_ack_o(kill_ack_i),
    .rsp_ready_o(rsp_ready_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [41:0] seen, logic [41:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Table load or free, one strobe cycle
  task automatic tbl(logic al, logic fr, logic [1:0] ix, ccr_ttype_t t, logic [28:0] ad);
    @(negedge mclk_i);
    {alloc_i, free_i, alloc_idx_i, free_idx_i} = {al, fr, ix, ix};
    alloc_typ_i = t;
    alloc_addr_i = ad;
    @(negedge mclk_i);
    {alloc_i, free_i} = 2'h0;
  endtask
  // One request, watched until the block is idle again
  task automatic run(ccr_ttype_t t, logic [28:0] a, logic [7:0] s, output logic [5:0] g);
    ccr_req_t r;
    r = '{t, a, s};
    g = '0;
    @(negedge mclk_i);
    in_req_i = r;
    in_valid_i = 1'b1;
    while (!in_ready_o) @(negedge mclk_i);
    @(negedge mclk_i);
    in_valid_i = 1'b0;
    chk("busy", in_ready_o, 1'b0);
    for (int k = 0; k < 40 && !in_ready_o; k++) begin
      if (rsp_valid_o) begin
        g[5:3] = {1'b1, rsp_o.code};
        chk("dst", rsp_o.dst, s);
      end
      if (fwd_valid_o) begin
        g[2] = 1'b1;
        chk("fwd", fwd_o, r);
      end
      if (dir_upd_o) begin
        g[1] = 1'b1;
        chk("dir", dir_addr_o, a);
      end
      if (kill_valid_o) begin
        g[0] = 1'b1;
        chk("kill", kill_excl_o, s);
      end
      @(negedge mclk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_iread();
    logic [5:0] g;
    tbl(1'b1, 1'b0, 2'h1, CCR_IREAD_HOME, 29'h0000100);
    foreach (home_l[i]) begin
      run(home_l[i], 29'h0000100, 8'h10, g);
      chk("ir_home", g, ERR);
    end
    run(CCR_CASTOUT, 29'h0000100, 8'h11, g);
    chk("ir_cast", g, ERR);
    run(CCR_IKILL_HOME, 29'h0000100, 8'h12, g);
    chk("ir_ikill", g, ERR);
    foreach (own_l[i]) begin
      run(own_l[i], 29'h0000100, 8'h20, g);
      chk("ir_own", g, FWD);
    end
    run(CCR_TLBIE, 29'h0000100, 8'h21, g);
    chk("ir_tlbie", g, FWD);
  endtask
  // Slow far side here
  task automatic t_rown();
    logic [5:0] g;
    wait_i = 4'h3;
    tbl(1'b1, 1'b0, 2'h2, CCR_READ_OWNER, 29'h0000200);
    foreach (home_l[i]) begin
      run(home_l[i], 29'h0000200, 8'h30, g);
      chk("ro_home", g, RTY);
    end
    foreach (own_l[i]) begin
      run(own_l[i], 29'h0000200, 8'h31, g);
      chk("ro_own", g, ERR);
    end
    run(CCR_CASTOUT, 29'h0000200, 8'h32, g);
    chk("ro_cast", g, DIR);
    run(CCR_TLBSYNC, 29'h0000200, 8'h33, g);
    chk("ro_sync", g, FWD);
    run(CCR_IKILL_HOME, 29'h0000200, 8'h34, g);
    chk("ro_ikill", g, KIL);
  endtask
  // Two hits on one granule, a miss, then a freed entry
  task automatic t_pair();
    logic [5:0] g;
    wait_i = 4'h0;
    tbl(1'b1, 1'b0, 2'h0, CCR_IREAD_HOME, 29'h0000200);
    run(CCR_READ_HOME, 29'h0000200, 8'h40, g);
    chk("low_idx", g, ERR);
    run(CCR_READ_HOME, 29'h0000201, 8'h41, g);
    chk("miss", g, PAS);
    tbl(1'b0, 1'b1, 2'h0, CCR_READ_HOME, 29'h0000000);
    run(CCR_READ_HOME, 29'h0000200, 8'h42, g);
    chk("freed", g, RTY);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_iread();
    t_rown();
    t_pair();
    complete_run();
  end
endmodule
